/* sgs_lag.sv */
`timescale 1ns/1ps
package sgs_pkg;
  localparam int DW             = 16;
  localparam int NRW            = 20;
  localparam int NREG           = 22;
  localparam int NCH            = 6;
  // Word indices, byte address is four times the index
  localparam int IDX_TUNE       = 0;
  localparam int IDX_LPF_SEL    = 1;
  localparam int IDX_LPF_MAN    = 2;
  localparam int IDX_MODEL_GAIN = 3;
  localparam int IDX_INERTIA    = 4;
  localparam int IDX_POS_GAIN   = 5;
  localparam int IDX_SPD_GAIN   = 6;
  localparam int IDX_SPD_INT    = 7;
  localparam int IDX_INERTIA_B  = 8;
  localparam int IDX_POS_GAIN_B = 9;
  localparam int IDX_SPD_GAIN_B = 10;
  localparam int IDX_SPD_INT_B  = 11;
  localparam int IDX_VIB_FREQ   = 12;
  localparam int IDX_RES_FREQ   = 13;
  localparam int IDX_VIB_FREQ_B = 14;
  localparam int IDX_RES_FREQ_B = 15;
  localparam int IDX_GS_SEL     = 16;
  localparam int IDX_GS_LEVEL   = 17;
  localparam int IDX_GS_TC      = 18;
  localparam int IDX_PIN_SEL    = 19;
  localparam int IDX_STATUS     = 20;
  localparam int IDX_CORNER     = 21;
  // Channel order: inertia, position, speed, integral, vibration, resonance
  localparam int NORM_IDX  [NCH] = '{4, 5, 6, 7, 12, 13};
  localparam int AFTER_IDX [NCH] = '{8, 9, 10, 11, 14, 15};
  localparam int CH_INERTIA     = 0;
  localparam int CH_SPD_GAIN    = 2;
  // Status bit positions
  localparam int ST_SWITCHED    = 0;
  localparam int ST_ENABLED     = 1;
  localparam int ST_TRIGGER     = 2;
  localparam logic [3:0] TUNE_MANUAL   = 4'h3;
  localparam logic [3:0] LPF_MAN_DIGIT = 4'h1;
  localparam logic [3:0] SEL_EXT       = 4'h1;
  localparam logic [3:0] SEL_CMDF      = 4'h2;
  localparam logic [3:0] SEL_DROOP     = 4'h3;
  localparam logic [3:0] SEL_SPEED     = 4'h4;
  // Inertia ratio is held in tenths, so 40 means 4.0 times
  localparam int LPF_MULT       = 10;
  localparam int INERTIA_SCALE  = 10;
  localparam int LAG_FRAC       = 8;
  localparam int MS_NS          = 1000000;
  localparam int CLK_NS         = 25;
  localparam int MS_CYCLES      = MS_NS / CLK_NS;
  localparam logic [NRW-1:0][15:0] REG_RST = {
    16'h0000, 16'h0064, 16'h0032, 16'h0000,
    16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8,
    16'h0032, 16'h0fa0, 16'h0054, 16'h0064,
    16'h0014, 16'h0bb8, 16'h0078, 16'h0028,
    16'h0064, 16'h0bb8, 16'h0000, 16'h0001};
  typedef enum logic [2:0] {
    COND_OFF   = 3'h0,
    COND_EXT   = 3'h1,
    COND_CMDF  = 3'h3,
    COND_DROOP = 3'h2,
    COND_SPEED = 3'h6
  } sgs_cond_e;
endpackage

// First-order lag, one step per millisecond tick
module sgs_lag #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         tick,
  input  wire logic         snap,
  input  wire logic [15:0]  tc,
  // Data
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] value
);
  localparam int FB = sgs_pkg::LAG_FRAC;
  typedef struct packed {
    logic [W+FB-1:0] acc;
  } sgs_lag_s;
  sgs_lag_s               s_q;
  sgs_lag_s               s_d;
  logic signed [W+FB:0]   diff;
  logic signed [W+FB:0]   step;

  always_comb begin
    s_d  = s_q;
    diff = $signed({1'b0, target, {FB{1'b0}}}) - $signed({1'b0, s_q.acc});
    step = (tc == 16'h0000) ? diff : diff / $signed({{(W+FB-16){1'b0}}, 1'b0, tc});
    // Without a minimum step the fraction would stall just short of the target
    if (step == '0 && diff != '0) begin
      step = diff[W+FB] ? '1 : (W+FB+1)'(1);
    end
    if (snap || tc == 16'h0000) begin
      s_d.acc = {target, {FB{1'b0}}};
    end else if (tick) begin
      s_d.acc = (W+FB)'($signed({1'b0, s_q.acc}) + step); // RULE_11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.acc[W+FB-1:FB];
endmodule

/* sgs_lpf_corner.sv */
`timescale 1ns/1ps
// Torque command low-pass corner in rad/s
module sgs_lpf_corner (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Inputs
  input  wire logic [15:0] speed_gain,
  input  wire logic [15:0] inertia_ratio,
  input  wire logic [15:0] manual_freq,
  input  wire logic        manual_sel,
  // Result
  output logic      [15:0] corner
);
  typedef struct packed {
    logic [15:0] corner;
  } sgs_lpf_s;
  sgs_lpf_s    s_q;
  sgs_lpf_s    s_d;
  logic [31:0] auto_freq;

  always_comb begin
    s_d       = s_q;
    // Inertia in tenths: gain / (1 + ratio) * 10 = gain * 100 / (10 + tenths)
    auto_freq = (32'(speed_gain) * 32'(sgs_pkg::LPF_MULT * sgs_pkg::INERTIA_SCALE))
              / (32'(sgs_pkg::INERTIA_SCALE) + 32'(inertia_ratio)); // RULE_01
    if (manual_sel) begin
      s_d.corner = manual_freq; // RULE_02
    end else if (auto_freq > 32'h0000ffff) begin
      s_d.corner = 16'hffff;
    end else begin
      s_d.corner = auto_freq[15:0]; // RULE_01
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign corner = s_q.corner;
endmodule

/* sgs_top.sv */
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Auto torque corner: speed gain/(1+inertia)x10
// RULE_02 - Second select digit 1 uses manual corner
// RULE_03 - Switch active loop gains on selected condition
// RULE_04 - Switching only in manual tuning mode 3
// RULE_05 - Model reference gain never switched
// RULE_06 - Switched: after-switch gains and inertia ratio used
// RULE_07 - Switched: after-switch vibration and resonance frequencies
// RULE_08 - Lowest select digit 1 selects external input
// RULE_09 - External input taken from a chosen pin
// RULE_10 - Compare command frequency, droop or speed to level
// RULE_11 - Switched gains pass a millisecond first-order lag
// RULE_12 - Host keeps after-switch inertia equal if unchanged
// RULE_13 - Select value 3 means droop pulse condition
// RULE_14 - Switched while trigger active or level reached
// RULE_15 - Select value 0 disables switching
module sgs_top #(
  parameter int NPIN      = 4,
  parameter int MS_CYCLES = sgs_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Gain switch input pins
  input  wire logic [NPIN-1:0] gain_switch_in,
  // Loop monitors
  input  wire logic [15:0]     command_freq,
  input  wire logic [15:0]     droop_pulses,
  input  wire logic [15:0]     motor_speed,
  // Active loop coefficients
  output logic      [15:0]     model_reference_gain,
  output logic      [15:0]     inertia_ratio,
  output logic      [15:0]     position_gain,
  output logic      [15:0]     speed_gain,
  output logic      [15:0]     speed_integral_time,
  output logic      [15:0]     vibration_freq,
  output logic      [15:0]     resonance_freq,
  output logic      [15:0]     torque_lpf_corner,
  output logic                 gain_switched
);
  localparam int PW = (NPIN > 1) ? $clog2(NPIN) : 1;

  typedef struct packed {
    logic [sgs_pkg::NRW-1:0][15:0] regs;
    logic [NPIN-1:0]               pin_s1;
    logic [NPIN-1:0]               pin_s2;
    logic [31:0]                   ms_cnt;
    logic                          ms_tick;
    logic                          switched;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } sgs_top_s;

  sgs_top_s                     s_q;
  sgs_top_s                     s_d;
  sgs_pkg::sgs_cond_e           cond;
  logic                         sw_en;
  logic                         trigger;
  logic [15:0]                  lvl;
  logic [PW-1:0]                pin_idx;
  logic [9:0]                   idx;
  logic [sgs_pkg::NCH-1:0][15:0] active;
  logic [15:0]                  corner;
  logic                         man_sel;
  logic                         use_after;

  function automatic logic [9:0] reg_idx(input logic [11:0] a);
    return a[11:2];
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 && reg_idx(a) < 10'(sgs_pkg::NREG);
  endfunction

  function automatic sgs_pkg::sgs_cond_e cond_of(input logic [3:0] digit);
    case (digit)
      sgs_pkg::SEL_EXT:   return sgs_pkg::COND_EXT;
      sgs_pkg::SEL_CMDF:  return sgs_pkg::COND_CMDF;
      sgs_pkg::SEL_DROOP: return sgs_pkg::COND_DROOP;
      sgs_pkg::SEL_SPEED: return sgs_pkg::COND_SPEED;
      default:            return sgs_pkg::COND_OFF;
    endcase
  endfunction

  always_comb begin
    cond    = cond_of(s_q.regs[sgs_pkg::IDX_GS_SEL][3:0]); // RULE_08
    sw_en   = s_q.regs[sgs_pkg::IDX_TUNE][3:0] == sgs_pkg::TUNE_MANUAL
              && cond != sgs_pkg::COND_OFF; // RULE_04 RULE_15
    lvl     = s_q.regs[sgs_pkg::IDX_GS_LEVEL];
    pin_idx = s_q.regs[sgs_pkg::IDX_PIN_SEL][PW-1:0];
    idx     = reg_idx(paddr);
    man_sel = s_q.regs[sgs_pkg::IDX_LPF_SEL][7:4] == sgs_pkg::LPF_MAN_DIGIT; // RULE_02
    // Leaving manual tuning drops the after-switch set at once, not a cycle later
    use_after = s_q.switched && sw_en; // RULE_04
    case (cond)
      sgs_pkg::COND_EXT:   trigger = s_q.pin_s2[pin_idx]; // RULE_08 RULE_09
      sgs_pkg::COND_CMDF:  trigger = command_freq >= lvl; // RULE_10
      sgs_pkg::COND_DROOP: trigger = droop_pulses >= lvl; // RULE_10 RULE_13
      sgs_pkg::COND_SPEED: trigger = motor_speed >= lvl; // RULE_10
      default:             trigger = 1'b0;
    endcase
  end

  always_comb begin
    s_d          = s_q;
    // Pins come from outside, two stages before anything looks at them
    s_d.pin_s1   = gain_switch_in;
    s_d.pin_s2   = s_q.pin_s1;
    s_d.ms_tick  = 1'b0;
    if (s_q.ms_cnt >= 32'(MS_CYCLES - 1)) begin
      s_d.ms_cnt  = '0;
      s_d.ms_tick = 1'b1;
    end else begin
      s_d.ms_cnt  = s_q.ms_cnt + 32'h0000_0001;
    end
    s_d.switched = sw_en && trigger; // RULE_03 RULE_14
    s_d.pready   = 1'b0;
    // One wait state so that read data leaves from a flip-flop
    if (psel && penable && !s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !mapped(paddr);
      s_d.prdata  = '0;
      if (mapped(paddr) && !pwrite) begin
        if (idx < 10'(sgs_pkg::NRW)) begin
          s_d.prdata = {16'h0000, s_q.regs[idx]};
        end else if (idx == 10'(sgs_pkg::IDX_STATUS)) begin
          s_d.prdata[sgs_pkg::ST_SWITCHED] = s_q.switched;
          s_d.prdata[sgs_pkg::ST_ENABLED]  = sw_en;
          s_d.prdata[sgs_pkg::ST_TRIGGER]  = trigger;
        end else begin
          s_d.prdata = {16'h0000, corner};
        end
      end
    end
    // Write lands on the edge that samples pready high; read-only words ignore it
    if (psel && penable && pwrite && s_q.pready && mapped(paddr) && idx < 10'(sgs_pkg::NRW)) begin
      s_d.regs[idx] = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q         <= '0;
      s_q.regs    <= sgs_pkg::REG_RST;
    end else begin
      s_q         <= s_d;
    end
  end

  // Lag is bypassed while switching is off, so plain gain edits act at once
  for (genvar k = 0; k < sgs_pkg::NCH; k++) begin : g_lag
    sgs_lag #(
      .W (sgs_pkg::DW)
    ) u_lag (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (s_q.ms_tick),
      .snap    (!sw_en),
      .tc      (s_q.regs[sgs_pkg::IDX_GS_TC]),
      .target  (use_after ? s_q.regs[sgs_pkg::AFTER_IDX[k]] : s_q.regs[sgs_pkg::NORM_IDX[k]]), // RULE_06 RULE_07
      .value   (active[k])
    );
  end

  sgs_lpf_corner u_lpf (
    .pclk          (pclk),
    .presetn       (presetn),
    .speed_gain    (active[sgs_pkg::CH_SPD_GAIN]),
    .inertia_ratio (active[sgs_pkg::CH_INERTIA]),
    .manual_freq   (s_q.regs[sgs_pkg::IDX_LPF_MAN]),
    .manual_sel    (man_sel),
    .corner        (corner)
  );

  assign prdata               = s_q.prdata;
  assign pready               = s_q.pready;
  assign pslverr              = s_q.pslverr;
  assign model_reference_gain = s_q.regs[sgs_pkg::IDX_MODEL_GAIN]; // RULE_05
  assign inertia_ratio        = active[0];
  assign position_gain        = active[1];
  assign speed_gain           = active[2];
  assign speed_integral_time  = active[3];
  assign vibration_freq       = active[4];
  assign resonance_freq       = active[5];
  assign torque_lpf_corner    = corner;
  assign gain_switched        = s_q.switched;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  model_gain_write_a: assert property ( // RULE_05
    psel && penable && pwrite && pready && paddr == 12'(sgs_pkg::IDX_MODEL_GAIN * 4)
    |=> model_reference_gain == $past(pwdata[15:0]))
    else $error("model reference gain not taken from write");

  model_gain_hold_a: assert property ( // RULE_05
    !(psel && penable && pwrite && pready) |=> $stable(model_reference_gain))
    else $error("model reference gain moved without a write");

  auto_tune_block_a: assert property ( // RULE_04
    s_q.regs[sgs_pkg::IDX_TUNE][3:0] != sgs_pkg::TUNE_MANUAL |=> !gain_switched)
    else $error("gain switched outside manual tuning");

  select_off_a: assert property ( // RULE_15
    s_q.regs[sgs_pkg::IDX_GS_SEL][3:0] == 4'h0 |=> !gain_switched)
    else $error("gain switched with select 0");

  droop_switch_a: assert property ( // RULE_13
    sw_en && s_q.regs[sgs_pkg::IDX_GS_SEL][3:0] == sgs_pkg::SEL_DROOP
    |=> gain_switched == ($past(droop_pulses) >= $past(lvl)))
    else $error("droop condition not followed");

  ext_pin_switch_a: assert property ( // RULE_08
    sw_en && cond == sgs_pkg::COND_EXT |-> ##1 gain_switched == $past(s_q.pin_s2[pin_idx]))
    else $error("external input condition not followed");

  speed_below_a: assert property ( // RULE_10
    cond == sgs_pkg::COND_SPEED && motor_speed < lvl |=> !gain_switched)
    else $error("switched below speed level");

  lpf_manual_a: assert property ( // RULE_02
    man_sel |=> torque_lpf_corner == $past(s_q.regs[sgs_pkg::IDX_LPF_MAN]))
    else $error("manual corner not applied");

  after_gain_a: assert property ( // RULE_06
    gain_switched && sw_en && s_q.regs[sgs_pkg::IDX_GS_TC] == 16'h0000
    |=> position_gain == $past(s_q.regs[sgs_pkg::IDX_POS_GAIN_B])
        && speed_gain == $past(s_q.regs[sgs_pkg::IDX_SPD_GAIN_B]))
    else $error("after-switch gains not applied");

  after_vib_a: assert property ( // RULE_07
    gain_switched && sw_en && s_q.regs[sgs_pkg::IDX_GS_TC] == 16'h0000
    |=> vibration_freq == $past(s_q.regs[sgs_pkg::IDX_VIB_FREQ_B]))
    else $error("after-switch vibration frequency not applied");

  normal_gain_a: assert property ( // RULE_03
    !sw_en |=> speed_integral_time == $past(s_q.regs[sgs_pkg::IDX_SPD_INT]))
    else $error("normal integral time not in effect");

  lag_soft_a: assert property ( // RULE_11
    sw_en && $rose(gain_switched) && $stable(sw_en) && s_q.regs[sgs_pkg::IDX_GS_TC] > 16'h0001
    && $past(position_gain) != s_q.regs[sgs_pkg::IDX_POS_GAIN_B] && $past(position_gain) == position_gain
    |=> position_gain != s_q.regs[sgs_pkg::IDX_POS_GAIN_B])
    else $error("position gain jumped without lag");

  bus_error_a: assert property (
    psel && penable && !pready && !mapped(paddr) |=> pready && pslverr)
    else $error("unmapped access not refused");

  after_resonance_a: assert property ( // RULE_06 RULE_07
    gain_switched && sw_en && s_q.regs[sgs_pkg::IDX_GS_TC] == 16'h0000
    |=> resonance_freq == $past(s_q.regs[sgs_pkg::IDX_RES_FREQ_B])
        && inertia_ratio == $past(s_q.regs[sgs_pkg::IDX_INERTIA_B]))
    else $error("after-switch resonance or inertia not applied");

  cmd_freq_switch_a: assert property ( // RULE_10
    sw_en && cond == sgs_pkg::COND_CMDF
    |=> gain_switched == ($past(command_freq) >= $past(lvl)))
    else $error("command frequency condition not followed");

  speed_above_a: assert property ( // RULE_14
    sw_en && cond == sgs_pkg::COND_SPEED && motor_speed >= lvl |=> gain_switched)
    else $error("not switched at speed level");

  status_flag_a: assert property ( // RULE_03
    psel && penable && !pwrite && !pready && paddr == 12'(sgs_pkg::IDX_STATUS * 4)
    |=> prdata[sgs_pkg::ST_SWITCHED] == $past(gain_switched))
    else $error("status switched bit wrong");

  ready_pulse_a: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  ext_switch_c: cover property (sw_en && cond == sgs_pkg::COND_EXT ##1 $rose(gain_switched));
  droop_switch_c: cover property (cond == sgs_pkg::COND_DROOP ##1 $rose(gain_switched) ##[1:50] $fell(gain_switched));
  lpf_manual_c: cover property (man_sel && pready);
  bus_error_c: cover property (pready && pslverr);
  lag_step_c: cover property (sw_en && s_q.regs[sgs_pkg::IDX_GS_TC] != 16'h0000 ##1 $rose(gain_switched));
endmodule

/* sgs_host_model.sv */
`timescale 1ns/1ps
// Host controller side: drives the gain switch pins as plain levels
module sgs_host_model #(
  parameter int NPIN = 4
) (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Requests from the bench
  input  wire logic [NPIN-1:0] want,
  input  wire logic            slow,
  // Pins toward the block
  output logic      [NPIN-1:0] gain_switch_in
);
  logic [NPIN-1:0] d1_q;
  logic [NPIN-1:0] d2_q;
  logic [NPIN-1:0] d3_q;

  // Slow mode models a host whose output stage lags by two more cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_q <= '0;
      d2_q <= '0;
      d3_q <= '0;
    end else begin
      d1_q <= want;
      d2_q <= d1_q;
      d3_q <= d2_q;
    end
  end

  // Pins are always driven, so no stale value can linger
  assign gain_switch_in = slow ? d3_q : d1_q;
endmodule

/* servo_gain_switch_and_torque_lpf_tb.sv */
`timescale 1ns/1ps
module servo_gain_switch_and_torque_lpf_tb;
  // Short lag tick keeps the run small
  localparam int MS = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, gsw, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  want, pins;
  logic [15:0] cmdf, droop, spd, mrg, inr, pg, sg, sit, vf, rf, cor;
  int          error_cnt, comparisons, cyc;

  sgs_top #(.NPIN(4), .MS_CYCLES(MS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gain_switch_in(pins), .command_freq(cmdf), .droop_pulses(droop), .motor_speed(spd),
    .model_reference_gain(mrg), .inertia_ratio(inr), .position_gain(pg), .speed_gain(sg),
    .speed_integral_time(sit), .vibration_freq(vf), .resonance_freq(rf), .torque_lpf_corner(cor),
    .gain_switched(gsw));

  sgs_host_model #(.NPIN(4)) host (.pclk(pclk), .presetn(presetn), .want(want), .slow(slow),
    .gain_switch_in(pins));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // Holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed wait: only the bench timeout ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int i, input logic [15:0] v);
    logic e;
    apb(1'b1, 12'(4 * i), {16'h0000, v}, e);
  endtask

  task automatic rchk(input int i, input logic [31:0] x);
    logic e;
    apb(1'b0, 12'(4 * i), 32'h0, e);
    chk(rd, x);
  endtask

  task automatic wait_sw(input logic v);
    int n;
    n = 0;
    while (gsw !== v && n < 30) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(gsw), 32'(v));
    repeat (2) @(posedge pclk);
  endtask

  // Latency from trigger to flag is a few cycles, so ten is ample
  task automatic no_sw();
    repeat (10) @(posedge pclk);
    chk(32'(gsw), 32'h0);
  endtask

  task automatic gains(input logic [15:0] i, p, s, t, v, r);
    chk(32'(mrg), 32'h64);
    chk(32'(inr), 32'(i));
    chk(32'(pg), 32'(p));
    chk(32'(sg), 32'(s));
    chk(32'(sit), 32'(t));
    chk(32'(vf), 32'(v));
    chk(32'(rf), 32'(r));
  endtask

  task automatic mon(input int k, input logic [15:0] v);
    @(posedge pclk);
    cmdf <= (k == 2) ? v : 16'hffff;
    droop <= (k == 3) ? v : 16'hffff;
    spd <= (k == 4) ? v : 16'hffff;
  endtask

  task automatic t_reset();
    for (int i = 0; i < sgs_pkg::NRW; i++) begin
      rchk(i, {16'h0000, sgs_pkg::REG_RST[i]});
    end
    rchk(sgs_pkg::IDX_STATUS, 32'h0);
    rchk(sgs_pkg::IDX_CORNER, 32'd6000);
    chk(32'(cor), 32'd6000);
    gains(16'd40, 16'd120, 16'd3000, 16'd20, 16'h03e8, 16'h03e8);
    $display("test reset done");
  endtask

  task automatic t_bus();
    logic e;
    apb(1'b0, 12'(4 * sgs_pkg::NREG), 32'h0, e);
    chk(rd, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 12'h00d, 32'h0, e);
    chk(32'(e), 32'h1);
    wr(sgs_pkg::IDX_CORNER, 16'h0001);
    rchk(sgs_pkg::IDX_CORNER, 32'd6000);
    wr(sgs_pkg::IDX_GS_LEVEL, 16'h1234);
    rchk(sgs_pkg::IDX_GS_LEVEL, 32'h1234);
    $display("test bus done");
  endtask

  task automatic t_lpf();
    wr(sgs_pkg::IDX_LPF_MAN, 16'd1234);
    wr(sgs_pkg::IDX_LPF_SEL, 16'h0010);
    repeat (4) @(posedge pclk);
    chk(32'(cor), 32'd1234);
    // Lowest digit set alone must not pick the manual corner
    wr(sgs_pkg::IDX_LPF_SEL, 16'h0001);
    repeat (4) @(posedge pclk);
    chk(32'(cor), 32'd6000);
    wr(sgs_pkg::IDX_INERTIA, 16'd0);
    wr(sgs_pkg::IDX_SPD_GAIN, 16'd2000);
    repeat (4) @(posedge pclk);
    chk(32'(cor), 32'd20000);
    wr(sgs_pkg::IDX_INERTIA, 16'd40);
    wr(sgs_pkg::IDX_SPD_GAIN, 16'd3000);
    $display("test lpf done");
  endtask

  task automatic t_ext();
    wr(sgs_pkg::IDX_TUNE, 16'h0003);
    wr(sgs_pkg::IDX_GS_SEL, 16'h0001);
    wr(sgs_pkg::IDX_PIN_SEL, 16'h0002);
    wr(sgs_pkg::IDX_GS_TC, 16'h0000);
    wr(sgs_pkg::IDX_VIB_FREQ_B, 16'h0123);
    wr(sgs_pkg::IDX_RES_FREQ_B, 16'h0456);
    @(posedge pclk);
    want <= 4'b1011;
    no_sw();
    slow <= 1'b1;
    want <= 4'b0100;
    wait_sw(1'b1);
    gains(16'd100, 16'd84, 16'd4000, 16'd50, 16'h0123, 16'h0456);
    repeat (2) @(posedge pclk);
    chk(32'(cor), 32'd3636);
    rchk(sgs_pkg::IDX_STATUS, 32'h7);
    want <= 4'b0000;
    slow <= 1'b0;
    wait_sw(1'b0);
    gains(16'd40, 16'd120, 16'd3000, 16'd20, 16'h03e8, 16'h03e8);
    $display("test external done");
  endtask

  task automatic t_gate();
    want <= 4'b0100;
    wait_sw(1'b1);
    // Model gain follows its own word only, switched or not
    wr(sgs_pkg::IDX_MODEL_GAIN, 16'h0070);
    @(posedge pclk);
    chk(32'(mrg), 32'h70);
    wr(sgs_pkg::IDX_MODEL_GAIN, 16'h0064);
    wr(sgs_pkg::IDX_TUNE, 16'h0001);
    no_sw();
    chk(32'(pg), 32'd120);
    rchk(sgs_pkg::IDX_STATUS, 32'h4);
    wr(sgs_pkg::IDX_TUNE, 16'h0003);
    wait_sw(1'b1);
    wr(sgs_pkg::IDX_GS_SEL, 16'h0000);
    no_sw();
    want <= 4'b0000;
    $display("test gating done");
  endtask

  task automatic t_level();
    wr(sgs_pkg::IDX_GS_LEVEL, 16'd50);
    for (int k = 2; k <= 4; k++) begin
      wr(sgs_pkg::IDX_GS_SEL, 16'(k));
      mon(k, 16'd49);
      no_sw();
      mon(k, 16'd50);
      wait_sw(1'b1);
      mon(k, 16'd0);
      wait_sw(1'b0);
    end
    $display("test level done");
  endtask

  task automatic t_lag();
    // Load does not change here, so both inertia settings match
    wr(sgs_pkg::IDX_INERTIA_B, 16'd40);
    wr(sgs_pkg::IDX_GS_TC, 16'd2);
    wr(sgs_pkg::IDX_GS_SEL, 16'h0004);
    mon(4, 16'd100);
    wait_sw(1'b1);
    repeat (MS + 2) @(posedge pclk);
    chk(32'(sg > 16'd3000 && sg < 16'd4000), 32'h1);
    repeat (400) @(posedge pclk);
    chk(32'(sg), 32'd4000);
    chk(32'(inr), 32'd40);
    $display("test lag done");
  endtask

  initial begin
    cyc = 0;
    error_cnt = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 4'h0;
    slow = 1'b0;
    cmdf = 16'h0000;
    droop = 16'h0000;
    spd = 16'h0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bus();
    t_lpf();
    t_ext();
    t_gate();
    t_level();
    t_lag();
    results();
  end
endmodule
